// ==== acs_pkg.sv ====
// Package for the converter channel-skip and result register block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package acs_pkg;

    // Printed offsets are not all multiples of four: index times four
    localparam logic [7:0] IDX_SKIP_FIRST   = 8'h2f;
    localparam logic [7:0] IDX_SKIP_SECOND  = 8'h30;
    localparam logic [7:0] IDX_IIN_RESULT   = 8'h31;
    localparam logic [7:0] IDX_IBAT_RESULT  = 8'h33;
    localparam logic [7:0] IDX_VBUS_RESULT  = 8'h35;
    localparam logic [7:0] IDX_VSRC1_RESULT = 8'h37;
    localparam logic [7:0] IDX_CONTROL      = 8'h3f;
    localparam logic [7:0] IDX_STATUS       = 8'h40;

    localparam int unsigned ADDR_W = 10;

    localparam logic [7:0]  SKIP_FIRST_MASK  = 8'hfe;
    localparam logic [7:0]  SKIP_SECOND_MASK = 8'hf0;
    localparam logic [7:0]  SKIP_RESET       = 8'h00;
    localparam logic [15:0] RESULT_RESET     = 16'h0000;

    // Control register fields
    localparam int unsigned CTRL_ENABLE_BIT  = 0;
    localparam int unsigned CTRL_REGRST_BIT  = 1;

    // Channel numbering of the sequencer, one per skip bit
    localparam int unsigned NUM_CH = 11;
    localparam logic [3:0] CH_IIN   = 4'h0;
    localparam logic [3:0] CH_IBAT  = 4'h1;
    localparam logic [3:0] CH_VBUS  = 4'h2;
    localparam logic [3:0] CH_VBAT  = 4'h3;
    localparam logic [3:0] CH_VSYS  = 4'h4;
    localparam logic [3:0] CH_TS    = 4'h5;
    localparam logic [3:0] CH_TDIE  = 4'h6;
    localparam logic [3:0] CH_DP    = 4'h7;
    localparam logic [3:0] CH_DM    = 4'h8;
    localparam logic [3:0] CH_VSRC2 = 4'h9;
    localparam logic [3:0] CH_VSRC1 = 4'ha;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [ADDR_W-1:0] adr;
        logic [31:0] dat;
    } acs_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } acs_wb_rsp_t;

    // Sample request to the converter core and its answer
    typedef struct packed {
        logic        valid;
        logic [3:0]  channel;
    } acs_conv_req_t;

    typedef struct packed {
        logic        done;
        logic [15:0] value;
    } acs_conv_rsp_t;

endpackage

// ==== acs_adc_regs.sv ====
// Channel-skip registers, result registers and conversion sequencer.
// Assumes a converter core that answers each request with one done pulse.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps

// Summary of operation
// - First skip register: bits 7..1 skip seven channels; bit 0 reads zero.
// - Second skip register: bits 7..4 skip four channels; bits 3..0 zero.
// - Skip bits read/write; 1 excludes channel; clear at reset and reg-reset.
// - Results are 16-bit read-only two's complement, zero until converted.
// - Input current positive toward mid-node, negative back to bus input.
// - Battery current positive while charging, negative while discharging.
// - Input current one mA per code, zero offset, at index 0x31.
// - Battery current one mA per code, zero offset, at index 0x33.
// - Bus voltage one mV per code, zero offset, at index 0x35.
module acs_adc_regs (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire acs_pkg::acs_wb_req_t  wb_req_i,
    output acs_pkg::acs_wb_rsp_t       wb_rsp_o,
    output acs_pkg::acs_conv_req_t     conv_req_o,
    input  wire acs_pkg::acs_conv_rsp_t conv_rsp_i,
    output logic                       conv_active_o
);
    import acs_pkg::*;

    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_PICK = 2'b01,
        ACS_WAIT = 2'b11
    } acs_state_t;

    logic [7:0]  skip_first_ff;
    logic [7:0]  skip_second_ff;
    logic        enable_ff;
    logic [15:0] iin_ff;
    logic [15:0] ibat_ff;
    logic [15:0] vbus_ff;
    logic [15:0] vsrc1_ff;
    logic        ack_ff;
    logic [31:0] rdat_ff;
    acs_state_t  state_ff;
    acs_state_t  nxt_state;
    logic [3:0]  chan_ff;
    logic [3:0]  nxt_chan;
    logic        req_ff;
    logic [NUM_CH-1:0] skip_vec;
    logic        access;
    logic        wr_acc;
    logic [7:0]  idx;
    logic        regrst;

    // Word index from byte address; low two bits ignored
    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:2];
    endfunction

    assign idx    = word_index(wb_req_i.adr);
    assign access = wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
    assign wr_acc = access & wb_req_i.we & wb_req_i.sel[0];
    assign regrst = wr_acc & (idx == IDX_CONTROL)
                    & wb_req_i.dat[CTRL_REGRST_BIT];

    // Skip vector in channel order
    assign skip_vec = {skip_second_ff[4], skip_second_ff[5],
                       skip_second_ff[6], skip_second_ff[7],
                       skip_first_ff[1], skip_first_ff[2],
                       skip_first_ff[3], skip_first_ff[4],
                       skip_first_ff[5], skip_first_ff[6],
                       skip_first_ff[7]};

    // Skip registers
    always_ff @(posedge clk_i) begin
        if (rst_i || regrst) begin
            skip_first_ff  <= SKIP_RESET;
            skip_second_ff <= SKIP_RESET;
        end else if (wr_acc && idx == IDX_SKIP_FIRST) begin
            skip_first_ff <= wb_req_i.dat[7:0] & SKIP_FIRST_MASK;
        end else if (wr_acc && idx == IDX_SKIP_SECOND) begin
            skip_second_ff <= wb_req_i.dat[7:0] & SKIP_SECOND_MASK;
        end
    end

    // Converter run enable; register-reset also stops conversions
    always_ff @(posedge clk_i) begin
        if (rst_i || regrst) begin
            enable_ff <= 1'b0;
        end else if (wr_acc && idx == IDX_CONTROL) begin
            enable_ff <= wb_req_i.dat[CTRL_ENABLE_BIT];
        end
    end

    // Sequencer: round robin over enabled channels
    always_comb begin
        nxt_state = state_ff;
        nxt_chan  = chan_ff;
        case (state_ff)
            ACS_IDLE: begin
                if (enable_ff) begin
                    nxt_state = ACS_PICK;
                end
            end
            ACS_PICK: begin
                if (!enable_ff) begin
                    nxt_state = ACS_IDLE;
                end else if (!skip_vec[chan_ff]) begin
                    nxt_state = ACS_WAIT;
                end else begin
                    nxt_chan = (chan_ff == 4'(NUM_CH - 1)) ? 4'h0
                               : chan_ff + 4'h1;
                end
            end
            ACS_WAIT: begin
                if (conv_rsp_i.done) begin
                    nxt_state = ACS_PICK;
                    nxt_chan  = (chan_ff == 4'(NUM_CH - 1)) ? 4'h0
                                : chan_ff + 4'h1;
                end
            end
            default: nxt_state = ACS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || regrst) begin
            state_ff <= ACS_IDLE;
            chan_ff  <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            chan_ff  <= nxt_chan;
        end
    end

    // One-cycle request when a wait begins
    always_ff @(posedge clk_i) begin
        if (rst_i || regrst) begin
            req_ff <= 1'b0;
        end else begin
            req_ff <= (state_ff == ACS_PICK) && (nxt_state == ACS_WAIT);
        end
    end

    assign conv_req_o.valid = req_ff;
    assign conv_req_o.channel = chan_ff;
    assign conv_active_o = (state_ff != ACS_IDLE);

    // Results; converter core delivers signed codes in 1 mA / 1 mV steps,
    // so the value is stored as is: sign gives current direction.
    // Reg-reset leaves results alone: they are measurements, not settings.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iin_ff   <= RESULT_RESET;
            ibat_ff  <= RESULT_RESET;
            vbus_ff  <= RESULT_RESET;
            vsrc1_ff <= RESULT_RESET;
        end else if (state_ff == ACS_WAIT && conv_rsp_i.done) begin
            case (chan_ff)
                CH_IIN:   iin_ff   <= conv_rsp_i.value;
                CH_IBAT:  ibat_ff  <= conv_rsp_i.value;
                CH_VBUS:  vbus_ff  <= conv_rsp_i.value;
                CH_VSRC1: vsrc1_ff <= conv_rsp_i.value;
                default: begin
                end
            endcase
        end
    end

    // Wishbone slave: ack one cycle after strobe, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= access;
            if (access && !wb_req_i.we) begin
                case (idx)
                    IDX_SKIP_FIRST:   rdat_ff <= {24'h0, skip_first_ff};
                    IDX_SKIP_SECOND:  rdat_ff <= {24'h0, skip_second_ff};
                    IDX_IIN_RESULT:   rdat_ff <= {16'h0, iin_ff};
                    IDX_IBAT_RESULT:  rdat_ff <= {16'h0, ibat_ff};
                    IDX_VBUS_RESULT:  rdat_ff <= {16'h0, vbus_ff};
                    IDX_VSRC1_RESULT: rdat_ff <= {16'h0, vsrc1_ff};
                    IDX_CONTROL:      rdat_ff <= {31'h0, enable_ff};
                    IDX_STATUS:       rdat_ff <= {27'h0, conv_active_o,
                                                  chan_ff};
                    default:          rdat_ff <= 32'h0000_0000;
                endcase
            end else begin
                rdat_ff <= 32'h0000_0000;
            end
        end
    end

    assign wb_rsp_o.ack = ack_ff;
    assign wb_rsp_o.dat = rdat_ff;

endmodule // acs_adc_regs

// ==== acs_checker.sv ====
// Port assertions for acs_adc_regs: bus answer and sequencer requests.
// Bound into the design at the foot of this file.
`timescale 1ns/10ps
module acs_checker (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire acs_pkg::acs_wb_req_t   wb_req_i,
    input wire acs_pkg::acs_wb_rsp_t   wb_rsp_o,
    input wire acs_pkg::acs_conv_req_t conv_req_o,
    input wire acs_pkg::acs_conv_rsp_t conv_rsp_i,
    input wire logic                   conv_active_o
);
    import acs_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic        rd;
    logic [9:0]  a;
    logic [31:0] d;
    assign rd = wb_rsp_o.ack && !wb_req_i.we;
    assign a = wb_req_i.adr;
    assign d = wb_rsp_o.dat;
    sequence take_s;
        wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    endsequence
    ack_next_a: assert property (take_s |=> wb_rsp_o.ack)
        else $error("No ack after request");
    ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("Ack held");
    idle_zero_a: assert property (!wb_rsp_o.ack |-> !d)
        else $error("Data without ack");
    skip_one_a: assert property (rd && a == 10'h0bc |-> d[31:8] == 24'h0 && !d[0])
        else $error("First skip reserved bits set");
    skip_two_a: assert property (rd && a == 10'h0c0 |-> d[31:8] == 24'h0 && d[3:0] == 4'h0)
        else $error("Second skip reserved bits set");
    result_wide_a: assert property (rd && a inside {10'h0c4, 10'h0cc, 10'h0d4, 10'h0dc} |-> d[31:16] == 16'h0)
        else $error("Result upper half set");
    req_pulse_a: assert property (conv_req_o.valid |=> !conv_req_o.valid)
        else $error("Sample request held");
    req_legal_a: assert property (conv_req_o.valid |-> conv_active_o && conv_req_o.channel < 4'hb)
        else $error("Bad sample request");
endmodule // acs_checker
bind acs_adc_regs acs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .conv_req_o(conv_req_o),
    .conv_rsp_i(conv_rsp_i), .conv_active_o(conv_active_o));

// ==== acs_adc_regs_tb_top.sv ====
// Testbench for acs_adc_regs: Wishbone master and converter responder.
// Assumes the checker binds itself from its own file.
`timescale 1ns/10ps
module acs_adc_regs_tb_top;
    import acs_pkg::*;
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    acs_wb_req_t   req = '0;
    acs_wb_rsp_t   rsp;
    acs_conv_req_t creq;
    acs_conv_rsp_t crsp = '0;
    logic          act;
    logic [15:0]   vals [0:10] = '{default: 16'h0};
    logic [10:0]   skipped = '0;
    int            mismatches = 0;
    int            num_checks = 0;
    int            cnt = 0;
    int            cyc = 0;
    acs_adc_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
        .wb_rsp_o(rsp), .conv_req_o(creq), .conv_rsp_i(crsp),
        .conv_active_o(act));
    always #5 clk_i = ~clk_i;
    // Converter answers every sample one cycle later
    always @(posedge clk_i) begin
        crsp.done <= creq.valid;
        if (creq.valid === 1'b1) begin
            crsp.value <= vals[creq.channel];
            cnt <= cnt + 1;
            if (skipped[creq.channel] !== 1'b0) begin
                mismatches++;
                $display("Error channel skipped %h seen %h", 1'b1, creq.channel);
            end
        end
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] i,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, 4'hf, {i, 2'b00}, d};
        do @(posedge clk_i); while (rsp.ack !== 1'b1);
        r = rsp.dat;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, i, 32'h0, r);
        num_checks++;
        if (r !== e) begin
            mismatches++;
            $display("Error reg %h expected %h seen %h", i, e, r);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, i, d, r);
    endtask
    task automatic t_reset;
        rd(IDX_SKIP_FIRST, 32'h0);
        rd(IDX_SKIP_SECOND, 32'h0);
        rd(IDX_IBAT_RESULT, 32'h0);
        wr(IDX_IIN_RESULT, 32'h1234);
        rd(IDX_IIN_RESULT, 32'h0);
        rd(8'h10, 32'h0);
        num_checks++;
        if (act !== 1'b0) begin
            mismatches++;
            $display("Error conv_active expected %b seen %b", 1'b0, act);
        end
    endtask
    task automatic t_skip;
        for (int b = 0; b < 8; b++) begin
            wr(IDX_SKIP_FIRST, 32'h1 << b);
            rd(IDX_SKIP_FIRST, (32'h1 << b) & 32'hfe);
            wr(IDX_SKIP_SECOND, 32'h1 << b);
            rd(IDX_SKIP_SECOND, (32'h1 << b) & 32'hf0);
        end
        wr(IDX_CONTROL, 32'h2);
        rd(IDX_SKIP_SECOND, 32'h0);
    endtask
    task automatic t_conv;
        int t;
        vals[0] <= 16'h1388;
        vals[1] <= 16'he0c0;
        vals[2] <= 16'h7530;
        vals[10] <= 16'h2ee0;
        skipped <= 11'h3f8;
        wr(IDX_SKIP_FIRST, 32'h1e);
        wr(IDX_SKIP_SECOND, 32'he0);
        wr(IDX_CONTROL, 32'h1);
        t = cnt + 8;
        while (cnt < t) @(posedge clk_i);
        rd(IDX_IIN_RESULT, 32'h1388);
        rd(IDX_IBAT_RESULT, 32'he0c0);
        rd(IDX_VBUS_RESULT, 32'h7530);
        rd(IDX_VSRC1_RESULT, 32'h2ee0);
        // Stop first so no answer in flight sees the new values
        wr(IDX_CONTROL, 32'h0);
        wr(IDX_SKIP_FIRST, 32'h9e);
        skipped <= 11'h3f9;
        vals[0] <= 16'hec78;
        vals[1] <= 16'h1f40;
        wr(IDX_CONTROL, 32'h1);
        t = cnt + 6;
        while (cnt < t) @(posedge clk_i);
        rd(IDX_IIN_RESULT, 32'h1388);
        rd(IDX_IBAT_RESULT, 32'h1f40);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_skip();
        t_conv();
        end_sim();
    end
endmodule // acs_adc_regs_tb_top
